//--- uart_efr_pkg.sv
/*
 * Package for the enhanced-feature register block: APB offsets, field
 * positions, reset values and timing constants.
 * Assumes a 50 MHz ref_clk and a 32-bit APB bus with byte-wide registers.
 */
package uart_efr_pkg;

    // ************
    // Register offsets (byte addresses)
    // ************
    localparam logic [7:0] scratch_off       = 8'h00;
    localparam logic [7:0] divisor_low_off   = 8'h04;
    localparam logic [7:0] divisor_high_off  = 8'h08;
    localparam logic [7:0] divisor_frac_off  = 8'h0c;
    localparam logic [7:0] trigger_off       = 8'h10;
    localparam logic [7:0] fifo_count_off    = 8'h14;
    localparam logic [7:0] feature_ctrl_off  = 8'h18;
    localparam logic [7:0] enhanced_off      = 8'h1c;
    localparam logic [7:0] line_ctrl_off     = 8'h20;
    localparam logic [7:0] int_status_off    = 8'h24;
    localparam logic [7:0] status_off        = 8'h28;
    localparam logic [7:0] rx_div_low_off    = 8'h2c;
    localparam logic [7:0] rx_div_high_off   = 8'h30;
    localparam logic [7:0] rx_div_frac_off   = 8'h34;
    localparam logic [7:0] rx_trigger_off    = 8'h38;
    localparam logic [7:0] tx_trigger_off    = 8'h3c;

    // ************
    // Field positions
    // ************
    localparam int fc_irda_inv    = 2;
    localparam int fc_rs485       = 3;
    localparam int fc_swap        = 6;
    localparam int fc_trig_sel    = 7;
    localparam int em_send_now    = 2;
    localparam int em_rts_inv     = 3;
    localparam int em_lsr_imm     = 6;
    localparam int em_xoff_mode   = 7;
    localparam int ef_enable      = 4;
    localparam int dd_indep       = 6;
    localparam int dd_select      = 7;

    // ************
    // Reset values and special codes
    // ************
    localparam logic [7:0] scratch_reset  = 8'hff;
    localparam logic [7:0] div_low_reset  = 8'h01;
    localparam logic [7:0] zero_byte      = 8'h00;
    localparam logic [7:0] lcr_enhanced   = 8'hbf;
    localparam logic [1:0] cnt_tx_mode    = 2'h1;
    localparam logic [1:0] cnt_alt_mode   = 2'h3;

    // ************
    // Timing
    // ************
    localparam int clk_mhz        = 50;
    localparam int clk_period_ns  = 1000 / clk_mhz;

    // One baud generator's settings
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
        logic [5:0] frac;
    } baud_cfg_type;

    // Receive flow-control match events
    typedef struct packed {
        logic xon;
        logic xoff;
        logic special;
    } flow_hit_type;

endpackage : uart_efr_pkg

//--- uart_enhanced_feature_regs.sv
/*
 * Enhanced-feature control block of a 16550-style UART: scratch swap,
 * FIFO level counts, send-immediately, RS-485 direction, interrupt modes,
 * dual fractional baud generators, trigger levels and flow-char select.
 * Assumes the FIFOs, shifters and status logic sit outside and report
 * their state here on the same clock; the RX pin is asynchronous.
 */
`timescale 1ns/100ps
module uart_enhanced_feature_regs #(
    parameter int count_width = 5
) (
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      nrst,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // FIFO and transmitter state
    input  wire logic                      fifo_enable,
    input  wire logic [count_width-1:0]    rx_count,
    input  wire logic [count_width-1:0]    tx_count,
    input  wire logic                      tx_holding_empty,
    input  wire logic                      tx_shift_empty,
    input  wire logic                      tx_last_stop_done,
    input  wire logic                      bypass_byte_sent,
    input  wire logic                      bit_tick,
    // Receive events
    input  wire logic                      rx_err_at_fifo,
    input  wire logic                      rx_err_at_holding,
    input  wire logic                      rx_char_done,
    input  uart_efr_pkg::flow_hit_type     flow_hit,
    input  wire logic                      rx_pin,
    // Outputs to the core
    output logic                           tx_bypass,
    output logic                           tx_fifo_write,
    output logic [7:0]                     tx_data,
    output logic                           rts_n,
    output logic                           tx_int,
    output logic                           line_err_int,
    output logic                           xoff_int,
    output logic                           xon_int,
    output logic                           special_int,
    output logic                           rx_data,
    output uart_efr_pkg::baud_cfg_type     tx_baud,
    output uart_efr_pkg::baud_cfg_type     rx_baud,
    output logic [1:0]                     sample_rate,
    output logic [3:0]                     tx_flow_sel,
    output logic [3:0]                     rx_flow_sel,
    output logic                           rx_match_either
);

    // ************
    // Bus decode
    // ************
    logic       wr_en, rd_en, alt_tx_q, rx_s1_q, rx_s2_q;
    logic       dir_tx_q, stop_seen_q, enh_on, swap_on;
    logic [7:0] wbyte, scratch_q, mode_q, feature_q, enhanced_q;
    logic [7:0] line_ctrl_q, frac_cfg_q, rx_trig_q, tx_trig_q;
    logic [7:0] rx_cnt8, tx_cnt8;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign wbyte   = pwdata[7:0];
    assign pready  = 1'b1;
    assign enh_on  = enhanced_q[uart_efr_pkg::ef_enable];
    assign swap_on = feature_q[uart_efr_pkg::fc_swap];
    assign rx_cnt8 = 8'(rx_count);
    assign tx_cnt8 = 8'(tx_count);
    function automatic logic is_unmapped(input logic [7:0] a);
        is_unmapped = (a > uart_efr_pkg::tx_trigger_off) | (a[1:0] != 2'h0);
    endfunction : is_unmapped
    assign pslverr = psel & penable & is_unmapped(paddr);

    // ************
    // Scratch byte and mode select
    // ************
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            scratch_q <= uart_efr_pkg::scratch_reset;
        end else if (wr_en && paddr == uart_efr_pkg::scratch_off
                     && !swap_on) begin
            scratch_q <= wbyte;
        end
    end
    // A same-cycle mode write beats the send-now clear when the byte leaves
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            mode_q <= uart_efr_pkg::zero_byte;
        end else if (wr_en && paddr == uart_efr_pkg::scratch_off
                     && swap_on) begin
            mode_q <= wbyte;
        end else if (bypass_byte_sent) begin
            mode_q[uart_efr_pkg::em_send_now] <= 1'b0;
        end
    end
    // Alternating pointer restarts on every mode write
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            alt_tx_q <= 1'b0;
        end else if (wr_en && paddr == uart_efr_pkg::scratch_off
                     && swap_on) begin
            alt_tx_q <= 1'b0;
        end else if (rd_en && paddr == uart_efr_pkg::scratch_off
                     && swap_on
                     && mode_q[1:0] == uart_efr_pkg::cnt_alt_mode) begin
            alt_tx_q <= ~alt_tx_q;
        end
    end

    // ************
    // Control registers
    // ************
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            feature_q   <= uart_efr_pkg::zero_byte;
            enhanced_q  <= uart_efr_pkg::zero_byte;
            line_ctrl_q <= uart_efr_pkg::zero_byte;
        end else if (wr_en) begin
            case (paddr)
                uart_efr_pkg::feature_ctrl_off: feature_q   <= wbyte;
                uart_efr_pkg::enhanced_off:     enhanced_q  <= wbyte;
                uart_efr_pkg::line_ctrl_off:    line_ctrl_q <= wbyte;
                default: ;
            endcase
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rx_trig_q <= uart_efr_pkg::zero_byte;
            tx_trig_q <= uart_efr_pkg::zero_byte;
        end else if (wr_en && paddr == uart_efr_pkg::trigger_off) begin
            if (feature_q[uart_efr_pkg::fc_trig_sel]) begin
                tx_trig_q <= wbyte;
            end else begin
                rx_trig_q <= wbyte;
            end
        end
    end

    // ************
    // Baud generators
    // ************
    localparam uart_efr_pkg::baud_cfg_type baud_reset =
        '{high: 8'h00, low: uart_efr_pkg::div_low_reset, frac: 6'h00};
    logic       dl_wr;
    logic       wr_tx_gen;
    logic       wr_rx_gen;
    logic [1:0] route;
    uart_efr_pkg::baud_cfg_type tx_baud_q;
    uart_efr_pkg::baud_cfg_type rx_baud_q;
    assign route = {frac_cfg_q[uart_efr_pkg::dd_select],
                    frac_cfg_q[uart_efr_pkg::dd_indep]};
    assign wr_tx_gen = (route == 2'h0) | (route == 2'h1);
    assign wr_rx_gen = (route == 2'h0) | (route == 2'h3);
    assign dl_wr     = wr_en & enh_on
                       & (paddr == uart_efr_pkg::divisor_frac_off);
    // One generator's settings after a divisor write
    function automatic uart_efr_pkg::baud_cfg_type baud_next(
        input uart_efr_pkg::baud_cfg_type cur
    );
        baud_next = cur;
        case (paddr)
            uart_efr_pkg::divisor_low_off:  baud_next.low  = wbyte;
            uart_efr_pkg::divisor_high_off: baud_next.high = wbyte;
            uart_efr_pkg::divisor_frac_off: begin
                if (enh_on) begin
                    baud_next.frac = wbyte[5:0];
                end
            end
            default: ;
        endcase
    endfunction : baud_next
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            frac_cfg_q <= uart_efr_pkg::zero_byte;
        end else if (dl_wr) begin
            frac_cfg_q <= wbyte;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            tx_baud_q <= baud_reset;
        end else if (wr_en && wr_tx_gen) begin
            tx_baud_q <= baud_next(tx_baud_q);
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rx_baud_q <= baud_reset;
        end else if (wr_en && wr_rx_gen) begin
            rx_baud_q <= baud_next(rx_baud_q);
        end
    end
    // Shared mode feeds both from the transmit copy
    assign tx_baud = tx_baud_q;
    assign rx_baud = frac_cfg_q[uart_efr_pkg::dd_indep] ? rx_baud_q
                                                        : tx_baud_q;
    // 00 gives 16X, 01 gives 8X, 1x gives 4X
    assign sample_rate = tx_baud_q.frac[5] ? 2'h2
                                           : {1'b0, tx_baud_q.frac[4]};

    // ************
    // Transmit path and direction control
    // ************
    logic tx_wr;
    assign tx_wr = wr_en & (paddr == uart_efr_pkg::status_off);
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            tx_bypass     <= 1'b0;
            tx_fifo_write <= 1'b0;
            tx_data       <= uart_efr_pkg::zero_byte;
        end else begin
            tx_bypass     <= tx_wr & fifo_enable
                             & mode_q[uart_efr_pkg::em_send_now];
            tx_fifo_write <= tx_wr & ~(fifo_enable
                             & mode_q[uart_efr_pkg::em_send_now]);
            if (tx_wr) begin
                tx_data <= wbyte;
            end
        end
    end
    // Wait for the next bit tick after the last stop bit before turning round
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            dir_tx_q    <= 1'b0;
            stop_seen_q <= 1'b0;
        end else if (tx_wr) begin
            dir_tx_q    <= 1'b1;
            stop_seen_q <= 1'b0;
        end else if (tx_last_stop_done && tx_shift_empty) begin
            stop_seen_q <= 1'b1;
        end else if (stop_seen_q && bit_tick) begin
            dir_tx_q    <= 1'b0;
            stop_seen_q <= 1'b0;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rts_n <= 1'b1;
        end else if (feature_q[uart_efr_pkg::fc_rs485]) begin
            rts_n <= ~dir_tx_q ^ mode_q[uart_efr_pkg::em_rts_inv];
        end else begin
            rts_n <= 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            tx_int <= 1'b0;
        end else if (feature_q[uart_efr_pkg::fc_rs485]) begin
            tx_int <= tx_holding_empty & tx_shift_empty;
        end else begin
            tx_int <= tx_holding_empty;
        end
    end

    // ************
    // Receive interrupts
    // ************
    logic isr_rd;
    logic lsr_src;
    assign isr_rd  = rd_en & (paddr == uart_efr_pkg::int_status_off);
    assign lsr_src = mode_q[uart_efr_pkg::em_lsr_imm] ? rx_err_at_fifo
                                                      : rx_err_at_holding;
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            line_err_int <= 1'b0;
        end else begin
            line_err_int <= lsr_src;
        end
    end
    // Set wins over every clear source
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            xoff_int <= 1'b0;
        end else if (flow_hit.xoff) begin
            xoff_int <= 1'b1;
        end else if (isr_rd || (flow_hit.xon
                     && !mode_q[uart_efr_pkg::em_xoff_mode])) begin
            xoff_int <= 1'b0;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            special_int <= 1'b0;
        end else if (flow_hit.special) begin
            special_int <= 1'b1;
        end else if (isr_rd || (rx_char_done
                     && !mode_q[uart_efr_pkg::em_xoff_mode])) begin
            special_int <= 1'b0;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            xon_int <= 1'b0;
        end else if (flow_hit.xon) begin
            xon_int <= 1'b1;
        end else if (isr_rd) begin
            xon_int <= 1'b0;
        end
    end

    // ************
    // Receive pin and flow selection
    // ************
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rx_s1_q <= 1'b0;
            rx_s2_q <= 1'b0;
            rx_data <= 1'b0;
        end else begin
            rx_s1_q <= rx_pin;
            rx_s2_q <= rx_s1_q;
            rx_data <= rx_s2_q ^ feature_q[uart_efr_pkg::fc_irda_inv];
        end
    end
    // One transmit pair lets receive both-pairs match either pair
    assign tx_flow_sel     = {2'h0, enhanced_q[3:2]};
    assign rx_flow_sel     = {2'h0, enhanced_q[1:0]};
    assign rx_match_either = (enhanced_q[1:0] == 2'h3)
                             & (enhanced_q[3:2] == 2'h1
                                | enhanced_q[3:2] == 2'h2);

    // ************
    // Read data
    // ************
    logic [7:0] count_sel, swap_rd, rd_byte;
    always_comb begin
        count_sel = feature_q[uart_efr_pkg::fc_trig_sel] ? tx_cnt8 : rx_cnt8;
        if (!mode_q[0]) begin
            swap_rd = rx_cnt8;
        end else if (mode_q[1:0] == uart_efr_pkg::cnt_tx_mode) begin
            swap_rd = tx_cnt8;
        end else begin
            swap_rd = alt_tx_q ? tx_cnt8 : rx_cnt8;
        end
        case (paddr)
            uart_efr_pkg::scratch_off:
                rd_byte = swap_on ? swap_rd : scratch_q;
            uart_efr_pkg::divisor_low_off:  rd_byte = tx_baud_q.low;
            uart_efr_pkg::divisor_high_off: rd_byte = tx_baud_q.high;
            uart_efr_pkg::divisor_frac_off:
                rd_byte = enh_on ? frac_cfg_q : 8'h00;
            uart_efr_pkg::fifo_count_off:
                rd_byte = (swap_on || line_ctrl_q == uart_efr_pkg::lcr_enhanced)
                          ? count_sel : 8'h00;
            uart_efr_pkg::feature_ctrl_off: rd_byte = feature_q;
            uart_efr_pkg::enhanced_off:     rd_byte = enhanced_q;
            uart_efr_pkg::line_ctrl_off:    rd_byte = line_ctrl_q;
            uart_efr_pkg::int_status_off:
                rd_byte = {4'h0, special_int, xoff_int, xon_int, line_err_int};
            uart_efr_pkg::status_off:
                rd_byte = {5'h0, dir_tx_q, tx_shift_empty, tx_holding_empty};
            uart_efr_pkg::rx_div_low_off:   rd_byte = rx_baud_q.low;
            uart_efr_pkg::rx_div_high_off:  rd_byte = rx_baud_q.high;
            uart_efr_pkg::rx_div_frac_off:  rd_byte = {2'h0, rx_baud_q.frac};
            uart_efr_pkg::rx_trigger_off:   rd_byte = rx_trig_q;
            uart_efr_pkg::tx_trigger_off:   rd_byte = tx_trig_q;
            default:                        rd_byte = 8'h00;
        endcase
    end

    assign prdata = {24'h0, rd_byte};

endmodule : uart_enhanced_feature_regs

//--- uart_efr_far_model.sv
/* Far-side model: FIFO levels and a transmit shifter.
   Assumes the block's transmit strobes on ref_clk. */
`timescale 1ns/100ps
module uart_efr_far_model (
    // Clock
    input  wire logic       ref_clk,
    // From the block
    input  wire logic       tx_bypass,
    input  wire logic       tx_fifo_write,
    // To the block
    output logic            tx_shift_empty,
    output logic            tx_last_stop_done,
    output logic            bypass_byte_sent,
    output logic            bit_tick,
    output logic [4:0]      rx_count,
    output logic [4:0]      tx_count
);
    int   t    = 0;
    int   busy = 0;
    logic byp  = 1'b0;
    assign rx_count = 5'h03;
    assign tx_count = 5'h07;
    initial begin
        {tx_last_stop_done, bypass_byte_sent, bit_tick} = 3'h0;
        tx_shift_empty = 1'b1;
    end
    // Forty cycles per byte, so a bit tick falls every four
    always @(posedge ref_clk) begin
        t              <= t + 1;
        bit_tick       <= t % 4 == 3;
        tx_shift_empty <= busy <= 1 && !(tx_bypass || tx_fifo_write);
        tx_last_stop_done <= busy == 1;
        bypass_byte_sent  <= busy == 1 && byp;
        if (tx_bypass || tx_fifo_write) begin
            busy <= 40;
            byp  <= tx_bypass;
        end else if (busy > 0)
            busy <= busy - 1;
    end
endmodule : uart_efr_far_model

//--- uart_efr_assertions.sv
/* Port checks for the enhanced-feature block.
   Assumes binding onto uart_enhanced_feature_regs. */
`timescale 1ns/100ps
module uart_efr_assertions (
    // Clock and reset
    input wire logic               ref_clk,
    input wire logic               nrst,
    // Observed ports
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [7:0]         paddr,
    input wire logic [31:0]        pwdata,
    input wire logic               fifo_enable,
    input wire logic               rx_char_done,
    input uart_efr_pkg::flow_hit_type flow_hit,
    input wire logic               tx_bypass,
    input wire logic               tx_fifo_write,
    input wire logic [7:0]         tx_data,
    input wire logic               xoff_int,
    input wire logic               xon_int,
    input wire logic               special_int
);
    wire acc   = psel && penable;
    wire rd_isr = acc && !pwrite && paddr == uart_efr_pkg::int_status_off;
    wire wr_tx = acc && pwrite && paddr == uart_efr_pkg::status_off;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    a_bypass_fifo: assert property (tx_bypass |-> $past(fifo_enable))
        else $error("bypass without fifo enable");
    a_bypass_single: assert property (
        tx_bypass |=> !tx_bypass && !tx_fifo_write)
        else $error("bypass longer than one byte");
    a_tx_taken: assert property (wr_tx |=> (tx_bypass ^ tx_fifo_write)
        && tx_data == $past(pwdata[7:0]))
        else $error("transmit byte not passed on");
    a_xon_sets: assert property (flow_hit.xon |=> xon_int)
        else $error("resume flag not set");
    a_xoff_sets: assert property (flow_hit.xoff |=> xoff_int)
        else $error("pause flag not set");
    a_xon_holds: assert property (xon_int && !rd_isr |=> xon_int)
        else $error("resume flag lost");
    a_xoff_holds: assert property (
        xoff_int && !rd_isr && !flow_hit.xon |=> xoff_int)
        else $error("pause flag lost");
    a_special_holds: assert property (special_int && !rd_isr
        && !rx_char_done && flow_hit == 3'h0 |=> special_int)
        else $error("special flag lost");
endmodule : uart_efr_assertions
bind uart_enhanced_feature_regs uart_efr_assertions u_chk (.ref_clk,
    .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .fifo_enable,
    .rx_char_done, .flow_hit, .tx_bypass, .tx_fifo_write, .tx_data,
    .xoff_int, .xon_int, .special_int);

//--- uart_enhanced_feature_regs_tb.sv
/* Self-checking bench: APB master and directed register tests.
   Assumes the far model; holding-empty is tied high. */
`timescale 1ns/100ps
module uart_enhanced_feature_regs_tb;
    logic        ref_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, fifo_enable = 1'b0, rx_char_done = 1'b0;
    logic        rx_err_at_fifo = 1'b0, rx_err_at_holding = 1'b0;
    logic        rx_pin = 1'b0, pready, pslverr, perr, tx_shift_empty;
    logic        tx_last_stop_done, bypass_byte_sent, bit_tick, tx_bypass;
    logic        tx_fifo_write, rts_n, tx_int, line_err_int, xoff_int;
    logic        xon_int, special_int, rx_data, rx_match_either;
    logic [7:0]  paddr = 8'h00, tx_data;
    logic [31:0] pwdata = 32'h0, prdata, seen;
    logic [4:0]  rx_count, tx_count;
    logic [1:0]  sample_rate;
    logic [3:0]  tx_flow_sel, rx_flow_sel;
    uart_efr_pkg::flow_hit_type flow_hit = 3'h0;
    uart_efr_pkg::baud_cfg_type tx_baud, rx_baud;
    int          err_total = 0, checks_done = 0, n_byp = 0, n_fw = 0;
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        n_byp <= n_byp + tx_bypass;
        n_fw  <= n_fw + tx_fifo_write;
    end
    uart_enhanced_feature_regs dut (.ref_clk, .nrst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fifo_enable,
        .rx_count, .tx_count, .tx_holding_empty(1'b1), .tx_shift_empty,
        .tx_last_stop_done, .bypass_byte_sent, .bit_tick, .rx_err_at_fifo,
        .rx_err_at_holding, .rx_char_done, .flow_hit, .rx_pin, .tx_bypass,
        .tx_fifo_write, .tx_data, .rts_n, .tx_int, .line_err_int,
        .xoff_int, .xon_int, .special_int, .rx_data, .tx_baud, .rx_baud,
        .sample_rate, .tx_flow_sel, .rx_flow_sel, .rx_match_either);
    uart_efr_far_model far (.ref_clk, .tx_bypass, .tx_fifo_write,
        .tx_shift_empty, .tx_last_stop_done, .bypass_byte_sent, .bit_tick,
        .rx_count, .tx_count);
    // ************
    // Bus and compare tasks
    // ************
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // Ends at a falling edge so outputs are settled for checks
    task automatic xfer(input logic [7:0] a, input logic w, logic [7:0] d);
        @(posedge ref_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        {seen, perr} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
        @(negedge ref_clk);
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        xfer(a, 1'b0, 8'h00);
        chk(seen, {24'h0, e});
    endtask : rd
    task automatic wait_rts(input logic v);
        repeat (100) if (rts_n !== v) @(negedge ref_clk);
        chk(rts_n, v);
    endtask : wait_rts
    task automatic flow(input logic [2:0] v);
        @(posedge ref_clk);
        flow_hit <= v;
        @(posedge ref_clk);
        flow_hit <= 3'h0;
        @(negedge ref_clk);
    endtask : flow
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    // ************
    // Tests
    // ************
    initial begin
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(uart_efr_pkg::scratch_off, 8'hff);
        wr(uart_efr_pkg::scratch_off, 8'h5a);
        rd(uart_efr_pkg::scratch_off, 8'h5a);
        rd(8'h40, 8'h00);
        chk(perr, 1'b1);
        wr(uart_efr_pkg::divisor_frac_off, 8'h25);
        rd(uart_efr_pkg::divisor_frac_off, 8'h00);
        wr(uart_efr_pkg::enhanced_off, 8'h10);
        wr(uart_efr_pkg::divisor_high_off, 8'h12);
        wr(uart_efr_pkg::divisor_frac_off, 8'h05);
        chk(tx_baud, {8'h12, 8'h01, 6'h05});
        chk(rx_baud, {8'h12, 8'h01, 6'h05});
        for (int i = 0; i < 4; i++) begin
            wr(uart_efr_pkg::divisor_frac_off, 8'(i << 4));
            chk(sample_rate, i > 1 ? 2 : i);
        end
        wr(uart_efr_pkg::enhanced_off, 8'h00);
        wr(uart_efr_pkg::divisor_frac_off, 8'h00);
        chk(sample_rate, 2'h2);
        wr(uart_efr_pkg::enhanced_off, 8'h10);
        wr(uart_efr_pkg::divisor_frac_off, 8'h40);
        wr(uart_efr_pkg::divisor_low_off, 8'h33);
        wr(uart_efr_pkg::divisor_frac_off, 8'hc0);
        wr(uart_efr_pkg::divisor_low_off, 8'h44);
        wr(uart_efr_pkg::divisor_frac_off, 8'h80);
        wr(uart_efr_pkg::divisor_low_off, 8'h55);
        chk(tx_baud.low, 8'h33);
        chk(rx_baud.low, 8'h33);
        rd(uart_efr_pkg::rx_div_low_off, 8'h44);
        wr(uart_efr_pkg::feature_ctrl_off, 8'h40);
        wr(uart_efr_pkg::scratch_off, 8'h00);
        rd(uart_efr_pkg::scratch_off, 8'h03);
        wr(uart_efr_pkg::scratch_off, 8'h01);
        rd(uart_efr_pkg::scratch_off, 8'h07);
        wr(uart_efr_pkg::scratch_off, 8'h03);
        for (int i = 0; i < 4; i++)
            rd(uart_efr_pkg::scratch_off, i % 2 ? 8'h07 : 8'h03);
        rd(uart_efr_pkg::fifo_count_off, 8'h03);
        wr(uart_efr_pkg::trigger_off, 8'h21);
        rd(uart_efr_pkg::rx_trigger_off, 8'h21);
        wr(uart_efr_pkg::feature_ctrl_off, 8'hc0);
        wr(uart_efr_pkg::trigger_off, 8'h0b);
        rd(uart_efr_pkg::tx_trigger_off, 8'h0b);
        rd(uart_efr_pkg::fifo_count_off, 8'h07);
        @(posedge ref_clk);
        fifo_enable <= 1'b1;
        wr(uart_efr_pkg::scratch_off, 8'h04);
        wr(uart_efr_pkg::status_off, 8'ha5);
        repeat (50) @(negedge ref_clk);
        wr(uart_efr_pkg::status_off, 8'h3c);
        @(negedge ref_clk);
        chk(n_byp, 1);
        chk(n_fw, 1);
        wr(uart_efr_pkg::feature_ctrl_off, 8'h48);
        wr(uart_efr_pkg::status_off, 8'h11);
        wait_rts(1'b0);
        wait_rts(1'b1);
        wr(uart_efr_pkg::scratch_off, 8'h08);
        wait_rts(1'b0);
        wr(uart_efr_pkg::status_off, 8'h22);
        wait_rts(1'b1);
        wait_rts(1'b0);
        chk(rx_data, 1'b0);
        wr(uart_efr_pkg::feature_ctrl_off, 8'h4c);
        repeat (2) @(negedge ref_clk);
        chk(rx_data, 1'b1);
        flow(3'b010);
        flow(3'b100);
        chk(xoff_int, 1'b0);
        rd(uart_efr_pkg::int_status_off, 8'h02);
        rd(uart_efr_pkg::int_status_off, 8'h00);
        wr(uart_efr_pkg::scratch_off, 8'h80);
        flow(3'b010);
        flow(3'b100);
        flow(3'b001);
        rd(uart_efr_pkg::int_status_off, 8'h0e);
        @(posedge ref_clk);
        rx_err_at_fifo <= 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(line_err_int, 1'b0);
        wr(uart_efr_pkg::scratch_off, 8'hc0);
        repeat (3) @(negedge ref_clk);
        chk(line_err_int, 1'b1);
        for (int j = 0; j < 4; j++) begin
            wr(uart_efr_pkg::enhanced_off, 8'h10);
            wr(uart_efr_pkg::enhanced_off, 8'(8'h13 | (j << 2)));
            chk(tx_flow_sel[1:0], j);
            chk(rx_flow_sel[1:0], 2'h3);
            chk(rx_match_either, j == 1 || j == 2);
        end
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        wrap_up();
    end
endmodule : uart_enhanced_feature_regs_tb
